// ===== rtl/ldao_pkg.sv
// Shared types and constants for the legacy deadlock avoidance ordering block.
package ldao_pkg;

    typedef enum logic [1:0] {
        CH_POSTED    = 2'b00,
        CH_NONPOSTED = 2'b01,
        CH_RESPONSE  = 2'b11
    } ldao_chan_type;

    typedef struct packed {
        ldao_chan_type chan;
        logic [31:0]   addr;
        logic          subtr_flag;
        logic [31:0]   payload;
    } ldao_pkt_type;

    typedef struct packed {
        logic [31:0] addr;
        logic        subtr_flag;
        logic        posted;
        logic [31:0] payload;
    } ldao_req_type;

    typedef enum logic [1:0] {
        SM_OTHER     = 2'b00,
        SM_HALT_ACK  = 2'b01,
        SM_STATE_REQ = 2'b10
    } ldao_sm_kind_type;

    typedef enum logic [1:0] {
        SM_IDLE      = 2'b00,
        SM_SEND_AS   = 2'b01,
        SM_WAIT_ACK  = 2'b11,
        SM_SEND_DE   = 2'b10
    } ldao_sm_state_type;

    localparam logic [31:0] LEGACY_BASE_RST   = 32'h000C_0000;
    localparam logic [31:0] LEGACY_LIMIT_RST  = 32'h000F_FFFF;
    localparam int          LEGACY_CAP_RST    = 1;
    localparam int          CNT_W             = 4;
    localparam logic [31:0] SM_CODE_ASSERT    = 32'h0000_0001;
    localparam logic [31:0] SM_CODE_DEASSERT  = 32'h0000_0002;

endpackage

// ===== rtl/ldao_chan_arb.sv
// Channel arbiter with a registered output stage that lets packets overtake.
`timescale 1ns/1ps
`default_nettype none
module ldao_chan_arb
    import ldao_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         p_valid_in,
    input  wire ldao_pkt_type p_pkt_in,
    output logic              p_ready_out,
    input  wire logic         np_valid_in,
    input  wire ldao_pkt_type np_pkt_in,
    output logic              np_ready_out,
    input  wire logic         r_valid_in,
    input  wire ldao_pkt_type r_pkt_in,
    output logic              r_ready_out,
    output logic              out_valid_out,
    output ldao_pkt_type      out_pkt_out,
    input  wire logic         out_ready_in
);
    logic         out_valid_q;
    logic         out_valid_d;
    ldao_pkt_type out_pkt_q;
    ldao_pkt_type out_pkt_d;
    logic         load;

    assign load = !out_valid_q || out_ready_in;

    always_comb begin
        p_ready_out  = load;                                  // (RULE12)
        r_ready_out  = load && !p_valid_in;                   // (RULE13)
        np_ready_out = load && !p_valid_in && !r_valid_in;    // (RULE3)
        out_valid_d  = out_valid_q && !out_ready_in;
        out_pkt_d    = out_pkt_q;
        if (load) begin
            out_valid_d = p_valid_in || r_valid_in || np_valid_in;
            if (p_valid_in) begin
                out_pkt_d = p_pkt_in;
            end else if (r_valid_in) begin
                out_pkt_d = r_pkt_in;
            end else if (np_valid_in) begin
                out_pkt_d = np_pkt_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            out_valid_q <= 1'b0;
            out_pkt_q   <= '0;
        end else begin
            out_valid_q <= out_valid_d;
            out_pkt_q   <= out_pkt_d;
        end
    end

    assign out_valid_out = out_valid_q;
    assign out_pkt_out   = out_pkt_q;

    a_posted_over_np: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (RULE12)
        load && p_valid_in && np_valid_in |=> out_pkt_q.chan == CH_POSTED)
        else $error("Posted packet did not overtake nonposted.");
    a_posted_over_rsp: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (RULE13)
        load && p_valid_in && r_valid_in |=> out_pkt_q.chan == CH_POSTED)
        else $error("Posted packet did not overtake response.");
    a_rsp_over_np: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (RULE3)
        load && !p_valid_in && r_valid_in && np_valid_in
        |=> out_valid_q && out_pkt_q.chan == CH_RESPONSE)
        else $error("Response did not overtake nonposted.");
endmodule
`default_nettype wire

// ===== rtl/ldao_top.sv
// Host issue control, legacy bridge buffering and clock stop sequencing.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RULE1) Legacy-bound host requests always go nonposted.
// (RULE2) Legacy when address decoded or subtractive flag.
// (RULE3) Responses overtake stalled nonposted requests.
// (RULE4) Outstanding legacy requests capped, typically one.
// (RULE5) Peers never send requests to legacy bus.
// (RULE6) Legacy quota never stalls forwarded requests.
// (RULE7) Separate buffer reserved for legacy-targeted requests.
// (RULE8) Management messages always accepted unconditionally.
// (RULE9) No new assert before acknowledge and deassert.
// (RULE10) State transition after throttle asserts immediately.
// (RULE11) Host ignores throttling asserts awaiting transition.
// (RULE12) Posted requests overtake stalled nonposted requests.
// (RULE13) Posted requests overtake waiting responses.
// (RULE14) Progress-critical traffic rides the posted channel.
// (RULE15) Counter of outstanding legacy requests holds issue.
module ldao_top
    import ldao_pkg::*;
#(
    parameter logic [31:0]      LEGACY_BASE  = LEGACY_BASE_RST,
    parameter logic [31:0]      LEGACY_LIMIT = LEGACY_LIMIT_RST,
    parameter logic [CNT_W-1:0] LEGACY_CAP   = CNT_W'(LEGACY_CAP_RST)
)(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             host_valid_in,
    input  wire ldao_req_type     host_req_in,
    output logic                  host_ready_out,
    input  wire logic             leg_rsp_in,
    input  wire logic             rsp_valid_in,
    input  wire ldao_pkt_type     rsp_pkt_in,
    output logic                  rsp_ready_out,
    output logic                  link_valid_out,
    output ldao_pkt_type          link_pkt_out,
    input  wire logic             link_ready_in,
    input  wire logic             dn_valid_in,
    input  wire ldao_pkt_type     dn_pkt_in,
    output logic                  dn_ready_out,
    output logic                  leg_valid_out,
    output ldao_pkt_type          leg_pkt_out,
    input  wire logic             leg_ready_in,
    output logic                  fwd_valid_out,
    output ldao_pkt_type          fwd_pkt_out,
    input  wire logic             fwd_ready_in,
    input  wire logic             sm_valid_in,
    input  wire ldao_sm_kind_type sm_kind_in,
    output logic                  sm_ready_out,
    input  wire logic             throttle_in,
    output logic [CNT_W-1:0]      leg_count_out,
    output logic                  clk_stop_active_out
);
    function automatic logic is_legacy(input logic [31:0] addr,
                                       input logic        subtr);
        is_legacy = subtr || (addr >= LEGACY_BASE && addr <= LEGACY_LIMIT);
    endfunction

    logic              host_leg;
    logic              host_stall;
    logic              host_acc;
    logic              p_valid;
    logic              np_valid;
    logic              p_ready;
    logic              np_ready;
    ldao_pkt_type      host_pkt;
    ldao_pkt_type      sm_pkt;
    ldao_pkt_type      p_pkt;
    logic              sm_send;
    logic              sm_sent;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    ldao_sm_state_type st_q;
    ldao_sm_state_type st_d;
    logic              thr_q;
    logic              thr_d;
    logic              pend_q;
    logic              pend_d;
    logic              trans_go;
    logic              ack_in;
    logic              sreq_in;
    logic              dn_leg;
    logic              leg_v_q;
    logic              leg_v_d;
    logic              fwd_v_q;
    logic              fwd_v_d;
    ldao_pkt_type      leg_q;
    ldao_pkt_type      leg_d;
    ldao_pkt_type      fwd_q;
    ldao_pkt_type      fwd_d;

    // Host issue path: classify, force nonposted, and throttle by count.
    always_comb begin
        host_leg   = is_legacy(host_req_in.addr, host_req_in.subtr_flag); // (RULE2)
        host_stall = host_leg && (cnt_q >= LEGACY_CAP);   // (RULE4)
        host_pkt.addr       = host_req_in.addr;
        host_pkt.subtr_flag = host_req_in.subtr_flag;
        host_pkt.payload    = host_req_in.payload;
        host_pkt.chan       = (host_req_in.posted && !host_leg)
                              ? CH_POSTED : CH_NONPOSTED;  // (RULE1)
        sm_pkt.chan       = CH_POSTED;                     // (RULE14)
        sm_pkt.addr       = '0;
        sm_pkt.subtr_flag = 1'b0;
        sm_pkt.payload    = (st_q == SM_SEND_AS) ? SM_CODE_ASSERT
                                                 : SM_CODE_DEASSERT;
        sm_send  = (st_q == SM_SEND_AS) || (st_q == SM_SEND_DE);
        p_valid  = sm_send ||
                   (host_valid_in && host_pkt.chan == CH_POSTED);
        p_pkt    = sm_send ? sm_pkt : host_pkt;
        np_valid = host_valid_in && !host_stall &&
                   host_pkt.chan == CH_NONPOSTED;
        if (host_pkt.chan == CH_POSTED) begin
            host_ready_out = p_ready && !sm_send;
        end else begin
            host_ready_out = np_ready && !host_stall;      // (RULE15)
        end
        host_acc = host_valid_in && host_ready_out;
        sm_sent  = sm_send && p_ready;
        cnt_d    = cnt_q;
        if ((host_acc && host_leg) && !leg_rsp_in) begin
            cnt_d = cnt_q + CNT_W'(1);                     // (RULE15)
        end else if (!(host_acc && host_leg) && leg_rsp_in &&
                     cnt_q != '0) begin
            cnt_d = cnt_q - CNT_W'(1);                     // (RULE15)
        end
    end

    ldao_chan_arb u_arb (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .p_valid_in   (p_valid),
        .p_pkt_in     (p_pkt),
        .p_ready_out  (p_ready),
        .np_valid_in  (np_valid),
        .np_pkt_in    (host_pkt),
        .np_ready_out (np_ready),
        .r_valid_in   (rsp_valid_in),
        .r_pkt_in     (rsp_pkt_in),
        .r_ready_out  (rsp_ready_out),
        .out_valid_out(link_valid_out),
        .out_pkt_out  (link_pkt_out),
        .out_ready_in (link_ready_in)
    );

    // Clock stop sequencing for the management controller.
    always_comb begin
        sm_ready_out = 1'b1;                               // (RULE8)
        ack_in   = sm_valid_in && sm_kind_in == SM_HALT_ACK;
        sreq_in  = sm_valid_in && sm_kind_in == SM_STATE_REQ;
        st_d     = st_q;
        thr_d    = thr_q;
        pend_d   = pend_q || sreq_in;
        trans_go = pend_d && (st_q == SM_IDLE ||
                              (st_q == SM_WAIT_ACK && thr_q));
        case (st_q)
            SM_IDLE: begin
                if (trans_go) begin
                    st_d   = SM_SEND_AS;
                    thr_d  = 1'b0;
                    pend_d = 1'b0;
                end else if (throttle_in) begin
                    st_d  = SM_SEND_AS;
                    thr_d = 1'b1;
                end
            end
            SM_SEND_AS: begin
                if (sm_sent) begin
                    st_d = SM_WAIT_ACK;
                end
            end
            SM_WAIT_ACK: begin
                if (trans_go) begin
                    st_d   = SM_SEND_AS;                   // (RULE10)
                    thr_d  = 1'b0;
                    pend_d = 1'b0;
                end else if (ack_in) begin
                    st_d = SM_SEND_DE;                     // (RULE9)
                end
            end
            SM_SEND_DE: begin
                if (sm_sent) begin
                    st_d = SM_IDLE;
                end
            end
            default: begin
                st_d = SM_IDLE;
            end
        endcase
    end

    // Legacy bridge node: a reserved slot apart from the forward buffer.
    always_comb begin
        dn_leg  = is_legacy(dn_pkt_in.addr, dn_pkt_in.subtr_flag);
        leg_v_d = leg_v_q && !leg_ready_in;
        fwd_v_d = fwd_v_q && !fwd_ready_in;
        leg_d   = leg_q;
        fwd_d   = fwd_q;
        dn_ready_out = dn_leg ? !leg_v_q : !fwd_v_q;      // (RULE6)
        if (dn_valid_in && dn_ready_out) begin
            if (dn_leg) begin
                leg_v_d = 1'b1;                            // (RULE7)
                leg_d   = dn_pkt_in;
            end else begin
                fwd_v_d = 1'b1;
                fwd_d   = dn_pkt_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q   <= '0;
            st_q    <= SM_IDLE;
            thr_q   <= 1'b0;
            pend_q  <= 1'b0;
            leg_v_q <= 1'b0;
            fwd_v_q <= 1'b0;
            leg_q   <= '0;
            fwd_q   <= '0;
        end else begin
            cnt_q   <= cnt_d;
            st_q    <= st_d;
            thr_q   <= thr_d;
            pend_q  <= pend_d;
            leg_v_q <= leg_v_d;
            fwd_v_q <= fwd_v_d;
            leg_q   <= leg_d;
            fwd_q   <= fwd_d;
        end
    end

    assign leg_valid_out       = leg_v_q;
    assign leg_pkt_out         = leg_q;
    assign fwd_valid_out       = fwd_v_q;
    assign fwd_pkt_out         = fwd_q;
    assign leg_count_out       = cnt_q;
    assign clk_stop_active_out = (st_q == SM_WAIT_ACK) ||
                                 (st_q == SM_SEND_DE);

    a_legacy_never_posted: assert property (@(posedge clk_in) // (RULE1)
        disable iff (!rst_n_in)
        link_valid_out && link_pkt_out.chan == CH_POSTED
        |-> !is_legacy(link_pkt_out.addr, link_pkt_out.subtr_flag))
        else $error("Legacy-bound request left in posted channel.");
    a_subtr_counted: assert property (@(posedge clk_in) // (RULE2)
        disable iff (!rst_n_in)
        host_acc && host_req_in.subtr_flag && !leg_rsp_in
        |=> cnt_q == $past(cnt_q) + CNT_W'(1))
        else $error("Subtractive request not counted as legacy.");
    a_cap_holds_issue: assert property (@(posedge clk_in) // (RULE15)
        disable iff (!rst_n_in)
        cnt_q == LEGACY_CAP && host_valid_in && host_leg
        |-> !host_ready_out)
        else $error("Legacy request issued at the cap.");
    a_count_bounded: assert property (@(posedge clk_in) // (RULE4)
        disable iff (!rst_n_in) cnt_q <= LEGACY_CAP)
        else $error("Outstanding legacy count above the cap.");
    a_fwd_not_blocked: assert property (@(posedge clk_in) // (RULE6)
        disable iff (!rst_n_in)
        dn_valid_in && !dn_leg && !fwd_v_q |-> dn_ready_out)
        else $error("Forwarded request stalled by legacy slot.");
    a_leg_slot_used: assert property (@(posedge clk_in) // (RULE7)
        disable iff (!rst_n_in)
        dn_valid_in && dn_leg && !leg_v_q
        |=> leg_v_q && leg_q == $past(dn_pkt_in) && fwd_v_q == $past(fwd_v_d))
        else $error("Legacy request not held in its reserved slot.");
    a_ack_then_deassert: assert property (@(posedge clk_in) // (RULE9)
        disable iff (!rst_n_in)
        st_q == SM_WAIT_ACK && !pend_q && !sreq_in
        |=> st_q != SM_SEND_AS)
        else $error("Clock stop reasserted before acknowledge.");
    a_trans_preempts: assert property (@(posedge clk_in) // (RULE10)
        disable iff (!rst_n_in)
        st_q == SM_WAIT_ACK && thr_q && sreq_in
        |=> st_q == SM_SEND_AS ##1 st_q == SM_SEND_AS || st_q == SM_WAIT_ACK)
        else $error("State transition waited for acknowledge.");
    a_sm_always_taken: assert property (@(posedge clk_in) // (RULE8)
        disable iff (!rst_n_in)
        st_q == SM_WAIT_ACK && ack_in && !trans_go
        |=> st_q == SM_SEND_DE)
        else $error("Management message not acted on.");
endmodule
`default_nettype wire

// ===== testbench/ldao_link_partner.sv
// Link sink partner that stalls on command and acknowledges clock stops.
`timescale 1ns/1ps
`default_nettype none
// The partner only sinks packets and returns halts; it never targets the
// legacy bus.
module ldao_link_partner
    import ldao_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         stall_in,
    input  wire logic         ack_en_in,
    input  wire logic         link_valid_in,
    input  wire ldao_pkt_type link_pkt_in,
    output logic              link_ready_out,
    output logic              ack_valid_out
);
    ldao_pkt_type got[$];
    int           wait_cnt = 0;
    always @(posedge clk_in) begin
        if (wait_cnt > 0) begin
            wait_cnt = wait_cnt - 1;
        end
        if (link_valid_in && link_ready_out) begin
            got.push_back(link_pkt_in);
            if (ack_en_in && link_pkt_in.chan == CH_POSTED &&
                link_pkt_in.payload == SM_CODE_ASSERT) begin
                wait_cnt = 3;
            end
        end
    end
    always @(negedge clk_in) begin
        link_ready_out <= !stall_in;
        ack_valid_out  <= (wait_cnt == 1);
    end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the ordering and issue control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
    import ldao_pkg::*;
    typedef struct packed {
        logic [31:0]   addr;
        logic          subtr;
        logic          posted;
        ldao_chan_type chan;
        logic          leg;
    } ldao_row_type;
    logic clk_in = 1'b0, rst_n_in = 1'b0, host_valid_in = 1'b0;
    logic leg_rsp_in = 1'b0, rsp_valid_in = 1'b0, dn_valid_in = 1'b0;
    logic leg_ready_in = 1'b0, fwd_ready_in = 1'b0, throttle_in = 1'b0;
    logic tb_sm_valid = 1'b0, stall = 1'b0, ack_en = 1'b0;
    logic host_ready_out, rsp_ready_out, link_valid_out, link_ready_in;
    logic dn_ready_out, leg_valid_out, fwd_valid_out, sm_ready_out;
    logic sm_valid_in, ack_valid, clk_stop_active_out;
    logic [CNT_W-1:0] leg_count_out;
    ldao_req_type     host_req_in = '0;
    ldao_pkt_type     rsp_pkt_in = '0, dn_pkt_in = '0, p;
    ldao_pkt_type     link_pkt_out, leg_pkt_out, fwd_pkt_out;
    ldao_sm_kind_type tb_sm_kind = SM_OTHER, sm_kind_in;
    int errors = 0, samples_checked = 0;
    ldao_row_type rows [6] = '{
        '{32'h000C_0000, 1'b0, 1'b1, CH_NONPOSTED, 1'b1},
        '{32'h000F_FFFF, 1'b0, 1'b1, CH_NONPOSTED, 1'b1},
        '{32'h000B_FFFF, 1'b0, 1'b1, CH_POSTED,    1'b0},
        '{32'h0010_0000, 1'b0, 1'b1, CH_POSTED,    1'b0},
        '{32'h2000_0000, 1'b1, 1'b1, CH_NONPOSTED, 1'b1},
        '{32'h2000_0000, 1'b0, 1'b0, CH_NONPOSTED, 1'b0}};
    assign sm_valid_in = tb_sm_valid | ack_valid;
    assign sm_kind_in  = ack_valid ? SM_HALT_ACK : tb_sm_kind;
    always #12.5 clk_in = ~clk_in;
    ldao_top i_ldao_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .host_valid_in(host_valid_in), .host_req_in(host_req_in),
        .host_ready_out(host_ready_out), .leg_rsp_in(leg_rsp_in),
        .rsp_valid_in(rsp_valid_in), .rsp_pkt_in(rsp_pkt_in),
        .rsp_ready_out(rsp_ready_out), .link_valid_out(link_valid_out),
        .link_pkt_out(link_pkt_out), .link_ready_in(link_ready_in),
        .dn_valid_in(dn_valid_in), .dn_pkt_in(dn_pkt_in),
        .dn_ready_out(dn_ready_out), .leg_valid_out(leg_valid_out),
        .leg_pkt_out(leg_pkt_out), .leg_ready_in(leg_ready_in),
        .fwd_valid_out(fwd_valid_out), .fwd_pkt_out(fwd_pkt_out),
        .fwd_ready_in(fwd_ready_in), .sm_valid_in(sm_valid_in),
        .sm_kind_in(sm_kind_in), .sm_ready_out(sm_ready_out),
        .throttle_in(throttle_in), .leg_count_out(leg_count_out),
        .clk_stop_active_out(clk_stop_active_out));
    ldao_link_partner i_ldao_link_partner (.clk_in(clk_in),
        .stall_in(stall), .ack_en_in(ack_en),
        .link_valid_in(link_valid_out), .link_pkt_in(link_pkt_out),
        .link_ready_out(link_ready_in), .ack_valid_out(ack_valid));
    task automatic xfer(ref logic v, ref logic r);
        int n;
        n = 0;
        @(negedge clk_in);
        v = 1'b1;
        #1;
        while (r !== 1'b1 && n < 300) begin
            @(negedge clk_in);
            #1;
            n++;
        end
        @(negedge clk_in);
        v = 1'b0;
        if (n >= 300) errors++;
    endtask
    task automatic send_host(input logic [31:0] a, input logic s,
                             input logic ps);
        host_req_in = '{addr: a, subtr_flag: s, posted: ps,
                        payload: a ^ 32'h5A5A_5A5A};
        xfer(host_valid_in, host_ready_out);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_in);
        s = 1'b1;
        @(negedge clk_in);
        s = 1'b0;
    endtask
    task automatic pop(output ldao_pkt_type q);
        int n;
        n = 0;
        while (i_ldao_link_partner.got.size() == 0 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        q = '0;
        if (n >= 300) errors++;
        else q = i_ldao_link_partner.got.pop_front();
    endtask
    task automatic overtake(input logic hp, input ldao_chan_type e1,
                            input ldao_chan_type e2);
        ldao_pkt_type q;
        stall = 1'b1;
        rsp_pkt_in = '{chan: CH_RESPONSE, addr: 32'h5000_0000,
                       subtr_flag: 1'b0, payload: 32'h0000_0077};
        fork
            xfer(rsp_valid_in, rsp_ready_out);
            send_host(32'h6000_0000, 1'b0, hp);
            begin
                repeat (6) @(negedge clk_in);
                stall = 1'b0;
            end
        join
        pop(q);
        `CHK(q.chan, e1)
        pop(q);
        `CHK(q.chan, e2)
    endtask
    task automatic stop_test();
        $display("Checked %0d values, %0d errors", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        foreach (rows[i]) begin
            send_host(rows[i].addr, rows[i].subtr, rows[i].posted);
            pop(p);
            `CHK(p.chan, rows[i].chan)
            `CHK(leg_count_out, CNT_W'(rows[i].leg))
            if (rows[i].leg) begin
                pulse(leg_rsp_in);
                `CHK(leg_count_out, '0)
            end
        end
        send_host(LEGACY_BASE_RST, 1'b0, 1'b0);
        pop(p);
        @(negedge clk_in);
        host_valid_in = 1'b1;
        repeat (3) @(negedge clk_in);
        `CHK(host_ready_out, 1'b0)
        `CHK(leg_count_out, CNT_W'(1))
        host_req_in.addr = 32'h3000_0000;
        #1;
        `CHK(host_ready_out, 1'b1)
        host_valid_in = 1'b0;
        pulse(leg_rsp_in);
        `CHK(leg_count_out, '0)
        dn_pkt_in = '{chan: CH_NONPOSTED, addr: 32'h4000_0000,
                      subtr_flag: 1'b0, payload: 32'h1111_1111};
        xfer(dn_valid_in, dn_ready_out);
        `CHK(fwd_valid_out, 1'b1)
        `CHK(fwd_pkt_out.addr, 32'h4000_0000)
        dn_pkt_in.addr = LEGACY_BASE_RST;
        dn_valid_in = 1'b1;
        #1;
        `CHK(dn_ready_out, 1'b1)
        @(negedge clk_in);
        dn_valid_in = 1'b0;
        `CHK(leg_valid_out, 1'b1)
        `CHK(leg_pkt_out.addr, LEGACY_BASE_RST)
        dn_pkt_in.addr = 32'h4000_0004;
        dn_valid_in = 1'b1;
        #1;
        `CHK(dn_ready_out, 1'b0)
        dn_valid_in = 1'b0;
        fwd_ready_in = 1'b1;
        leg_ready_in = 1'b1;
        @(negedge clk_in);
        `CHK(fwd_valid_out, 1'b0)
        `CHK(leg_valid_out, 1'b0)
        overtake(1'b0, CH_RESPONSE, CH_NONPOSTED);
        overtake(1'b1, CH_POSTED, CH_RESPONSE);
        ack_en = 1'b1;
        stall = 1'b1;
        xfer(rsp_valid_in, rsp_ready_out);
        fork
            send_host(32'h6000_0010, 1'b0, 1'b0);
            pulse(throttle_in);
            begin
                repeat (6) @(negedge clk_in);
                stall = 1'b0;
            end
        join
        pop(p);
        pop(p);
        `CHK(p.payload, SM_CODE_ASSERT)
        pop(p);
        `CHK(p.chan, CH_NONPOSTED)
        pop(p);
        `CHK(p.payload, SM_CODE_DEASSERT)
        ack_en = 1'b0;
        pulse(throttle_in);
        pop(p);
        `CHK(p.payload, SM_CODE_ASSERT)
        `CHK(clk_stop_active_out, 1'b1)
        pulse(throttle_in);
        tb_sm_kind = SM_OTHER;
        xfer(tb_sm_valid, sm_ready_out);
        repeat (10) @(negedge clk_in);
        `CHK(i_ldao_link_partner.got.size(), 0)
        `CHK(clk_stop_active_out, 1'b1)
        tb_sm_kind = SM_HALT_ACK;
        xfer(tb_sm_valid, sm_ready_out);
        pop(p);
        `CHK(p.payload, SM_CODE_DEASSERT)
        repeat (2) @(negedge clk_in);
        `CHK(clk_stop_active_out, 1'b0)
        send_host(LEGACY_BASE_RST, 1'b0, 1'b1);
        pop(p);
        pulse(throttle_in);
        pop(p);
        tb_sm_kind = SM_STATE_REQ;
        @(negedge clk_in);
        tb_sm_valid = 1'b1;
        #1;
        `CHK(sm_ready_out, 1'b1)
        @(negedge clk_in);
        tb_sm_valid = 1'b0;
        pop(p);
        `CHK(p.chan, CH_POSTED)
        `CHK(p.payload, SM_CODE_ASSERT)
        stall = 1'b1;
        send_host(32'h7000_0000, 1'b0, 1'b1);
        @(negedge clk_in);
        rst_n_in = 1'b0;
        @(negedge clk_in);
        `CHK(leg_count_out, '0)
        `CHK(link_valid_out, 1'b0)
        `CHK(clk_stop_active_out, 1'b0)
        rst_n_in = 1'b1;
        stop_test();
    end
endmodule
`default_nettype wire
